// ===== design/spread_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "touch_output_health_pulse_defines.svh"

interface spread_if;
  logic                      burstActive;
  logic signed [`TRIM_W-1:0] trim;

  modport sequencer (output burstActive, input trim);
  modport modulator (input burstActive, output trim);
endinterface
`default_nettype wire

// ===== design/spread_modulator.sv
`timescale 1ns/10ps
`default_nettype none
`include "touch_output_health_pulse_defines.svh"

module spread_modulator (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Link to the sequencer.
  spread_if.modulator spr
);

  localparam logic signed [`TRIM_W-1:0] LIMIT = `TRIM_W'(`SPREAD_PERMILLE);
  localparam logic signed [`TRIM_W-1:0] TRIM_STEP = `TRIM_W'(1);

  logic [3:0] stepCount;
  logic       rising;
  logic signed [`TRIM_W-1:0] trimReg;

  assign spr.trim = trimReg;

  ////////////////////////////////////////////////////////////////////////////
  // Triangle sweep of the oscillator trim, in per-mille, only in a burst.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stepCount <= 4'h0;
      rising    <= 1'b1;
      trimReg   <= '0;
    end else if (clkEn) begin
      if (!spr.burstActive) begin
        stepCount <= 4'h0;
        trimReg   <= '0;
      end else if (stepCount == `SPREAD_STEP) begin
        stepCount <= 4'h0;
        if (rising && trimReg >= LIMIT) begin
          rising  <= 1'b0;
          trimReg <= trimReg - TRIM_STEP;
        end else if (!rising && trimReg <= -LIMIT) begin
          rising  <= 1'b1;
          trimReg <= trimReg + TRIM_STEP;
        end else if (rising) begin
          trimReg <= trimReg + TRIM_STEP;
        end else begin
          trimReg <= trimReg - TRIM_STEP;
        end
      end else begin
        stepCount <= stepCount + 4'h1;
      end
    end
  end

endmodule // spread_modulator
`default_nettype wire

// ===== design/touch_output_health_pulse.sv
`timescale 1ns/10ps
`default_nettype none
`include "touch_output_health_pulse_defines.svh"

module touch_output_health_pulse #(
  parameter int unsigned FAST_GAP_CYCLES = `FAST_GAP_US * `CLK_MHZ,
  parameter int unsigned LOWPWR_SLEEP_CYCLES =
    `LOWPWR_SLEEP_MS * 1000 * `CLK_MHZ
) (
  // Clock, reset and enable.
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      clkEn,
  // Pace pin.
  input  wire logic                      paceIn,
  // Measurement result from acquisition.
  input  wire logic                      measDone,
  input  wire logic                      measExceeds,
  // Burst control.
  output logic                           burstActive,
  output logic signed [`TRIM_W-1:0]      oscTrim,
  output logic                           recalRequest,
  // Detect pin.
  output logic                           detectOut,
  output logic                           detectOe
);

  spread_if spr ();

  touch_output_pkg::phase_t     phase;
  touch_output_pkg::pace_mode_t mode;
  logic [`GAP_W-1:0]            gapCount;
  logic [`HEALTH_W-1:0]         healthCount;
  logic [2:0]                   consensus;
  logic [`BURSTS_W-1:0]         onBursts;
  logic                         detect;
  logic                         pacePrev;
  logic [`GAP_W-1:0]            gapLimit;
  logic                         resolving;
  logic                         paceEdge;
  logic                         stuck;
  logic                         wake;
  logic                         healthLast;
  logic                         paceValid;

  spread_modulator u_spread (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .spr     (spr)
  );

  function automatic logic burstEnds(touch_output_pkg::phase_t p,
                                     logic done);
    return (p == touch_output_pkg::BURST) && done;
  endfunction

  assign spr.burstActive = (phase == touch_output_pkg::BURST);

  ////////////////////////////////////////////////////////////////////////////
  // Gap selection and events.
  assign resolving = (consensus != 3'h0) && !detect;
  assign paceEdge  = paceValid && (paceIn != pacePrev);
  assign stuck     = detect && measExceeds
                     && (onBursts == `BURSTS_W'(`MAX_ON_BURSTS - 1));
  // A pace edge is ignored while a touch is being resolved.
  assign wake      = (mode == touch_output_pkg::PACED && paceEdge
                      && !resolving)
                     || (gapCount >= gapLimit - `GAP_W'(1));
  assign healthLast = (healthCount == `HEALTH_W'(`HEALTH_CYCLES - 1));

  always_comb begin
    if (mode == touch_output_pkg::FAST || resolving) begin
      gapLimit = `GAP_W'(FAST_GAP_CYCLES);
    end else begin
      gapLimit = `GAP_W'(LOWPWR_SLEEP_CYCLES);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pacePrev <= 1'b0;
    end else if (clkEn) begin
      pacePrev <= paceIn;
    end
  end

  // The first sample after reset has no history, so it makes no edge.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      paceValid <= 1'b0;
    end else if (clkEn) begin
      paceValid <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencer: sleep, health float, burst.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase       <= touch_output_pkg::SLEEP;
      gapCount    <= '0;
      healthCount <= '0;
    end else if (clkEn) begin
      unique case (phase)
        touch_output_pkg::SLEEP: begin
          if (wake) begin
            phase       <= touch_output_pkg::HEALTH;
            gapCount    <= '0;
            healthCount <= '0;
          end else begin
            gapCount <= gapCount + `GAP_W'(1);
          end
        end
        touch_output_pkg::HEALTH: begin
          if (healthLast) begin
            phase <= touch_output_pkg::BURST;
          end else begin
            healthCount <= healthCount + `HEALTH_W'(1);
          end
        end
        touch_output_pkg::BURST: begin
          if (measDone) begin
            phase    <= touch_output_pkg::SLEEP;
            gapCount <= '0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run mode, picked from the pace pin at each burst end and during sleep.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= touch_output_pkg::LOWPWR;
    end else if (clkEn) begin
      if (burstEnds(phase, measDone)) begin
        if (paceIn) begin
          mode <= touch_output_pkg::FAST;
        end else if (mode == touch_output_pkg::FAST) begin
          mode <= touch_output_pkg::PACED;
        end
      end else if (phase == touch_output_pkg::SLEEP
                   && mode == touch_output_pkg::LOWPWR && paceEdge) begin
        mode <= touch_output_pkg::PACED;
      end else if (phase == touch_output_pkg::SLEEP
                   && mode == touch_output_pkg::PACED && !paceEdge
                   && gapCount >= `GAP_W'(LOWPWR_SLEEP_CYCLES)
                                   - `GAP_W'(1)) begin
        mode <= paceIn ? touch_output_pkg::FAST : touch_output_pkg::LOWPWR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Consensus filter, detect state and stuck timeout.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      consensus    <= 3'h0;
      detect       <= 1'b0;
      onBursts     <= '0;
      recalRequest <= 1'b0;
    end else if (clkEn) begin
      recalRequest <= 1'b0;
      if (burstEnds(phase, measDone)) begin
        if (!measExceeds) begin
          consensus <= 3'h0;
          detect    <= 1'b0;
          onBursts  <= '0;
        end else if (stuck) begin
          consensus    <= 3'h0;
          detect       <= 1'b0;
          onBursts     <= '0;
          recalRequest <= 1'b1;
        end else if (detect) begin
          onBursts <= onBursts + `BURSTS_W'(1);
        end else if (consensus == `CONSENSUS_LIMIT - 3'h1) begin
          consensus <= `CONSENSUS_LIMIT;
          detect    <= 1'b1;
        end else begin
          consensus <= consensus + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive, floated during the health interval.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      detectOut <= 1'b0;
    end else if (clkEn) begin
      detectOut <= detect;
    end
  end

  // The float starts with the health phase and ends as the burst starts.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      detectOe <= 1'b1;
    end else if (clkEn) begin
      if (phase == touch_output_pkg::SLEEP) begin
        detectOe <= !wake;
      end else if (phase == touch_output_pkg::HEALTH) begin
        detectOe <= healthLast;
      end else begin
        detectOe <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscTrim <= '0;
    end else if (clkEn) begin
      oscTrim <= spr.trim;
    end
  end

  assign burstActive = spr.burstActive;

endmodule // touch_output_health_pulse
`default_nettype wire

// ===== design/touch_output_health_pulse_defines.svh
`ifndef TOUCH_OUTPUT_HEALTH_PULSE_DEFINES_SVH
`define TOUCH_OUTPUT_HEALTH_PULSE_DEFINES_SVH

`define CLK_MHZ          100
`define HEALTH_US        15
`define HEALTH_CYCLES    (`HEALTH_US * `CLK_MHZ)
`define FAST_GAP_US      1000
`define LOWPWR_SLEEP_MS  80
`define MAX_ON_S         60
`define MAX_ON_BURSTS    ((`MAX_ON_S * 1000) / `LOWPWR_SLEEP_MS)
`define CONSENSUS_LIMIT  3'h4
`define SPREAD_PERMILLE  75
`define SPREAD_STEP      4'hF
`define GAP_W            32
`define HEALTH_W         11
`define BURSTS_W         10
`define TRIM_W           8

`endif

// ===== design/touch_output_pkg.sv
package touch_output_pkg;

  typedef enum logic [1:0] {SLEEP, HEALTH, BURST} phase_t;

  typedef enum logic [1:0] {FAST, LOWPWR, PACED} pace_mode_t;

endpackage

// ===== verif/health_receiver.sv
`timescale 1ns/10ps
`default_nettype none
module health_receiver #(parameter int BLANK = 100) (
  // Clock and reset.
  input wire logic  sys_clk,
  input wire logic  rst_n,
  // Detect pin.
  input wire logic  detectOut,
  input wire logic  detectOe,
  output logic      pin,
  output int        pulses,
  output int        swPulses
);
  int   age;
  logic pinQ;
  logic lastLevel;
  logic swPin;
  logic swPinQ;
  assign pin = detectOe ? detectOut : 1'b1;
  // A switched load pulls against the last driven level, so floats show.
  assign swPin = detectOe ? detectOut : !lastLevel;
  // Counts float pulses once the start-up blanking is over.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      age <= 0;
      pinQ <= 1'b1;
      pulses <= 0;
      lastLevel <= 1'b0;
      swPinQ <= 1'b0;
      swPulses <= 0;
    end else begin
      pinQ <= pin;
      swPinQ <= swPin;
      if (detectOe) lastLevel <= detectOut;
      if (age < BLANK) age <= age + 1;
      else begin
        if (pin && !pinQ && !detectOe) pulses <= pulses + 1;
        if (swPin != swPinQ && !detectOe) swPulses <= swPulses + 1;
      end
    end
  end
endmodule // health_receiver
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "touch_output_health_pulse_defines.svh"
module testbench;
  logic sys_clk, rst_n, clkEn, paceIn, measDone, measExceeds, det;
  logic burstActive, recalRequest, detectOut, detectOe, pin;
  logic signed [`TRIM_W-1:0] oscTrim;
  logic [31:0] rnd;
  logic        q[$];
  int          pulses, fails, samples_checked, expPulses, cons;
  int          swPulses, expFloats;
  touch_output_health_pulse #(.FAST_GAP_CYCLES(200), .LOWPWR_SLEEP_CYCLES(2000))
    i_touch_output_health_pulse (.sys_clk, .rst_n, .clkEn, .paceIn,
    .measDone, .measExceeds, .burstActive, .oscTrim, .recalRequest,
    .detectOut, .detectOe);
  health_receiver i_health_receiver (.sys_clk, .rst_n, .detectOut,
    .detectOe, .pin, .pulses, .swPulses);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Waits for the float, then the burst, then ends it with one result.
  task automatic burst(input logic ex, input int gap);
    int   k;
    logic seen;
    k = 0;
    seen = 1'b0;
    while (detectOe !== 1'b0 && k < 5000) begin
      @(posedge sys_clk);
      #1 k++;
    end
    check("gap", 1'b1, k > gap - 5 && k < gap + 5);
    if (!det) expPulses++;
    expFloats++;
    k = 0;
    while (burstActive !== 1'b1 && k < 2000) begin
      @(posedge sys_clk);
      #1 k++;
    end
    repeat (40) begin
      @(posedge sys_clk);
      #1 seen |= (oscTrim !== '0);
    end
    check("trim", 1'b1, seen);
    measDone = 1'b1;
    measExceeds = ex;
    @(posedge sys_clk);
    #1 measDone = 1'b0;
    cons = ex ? cons + 1 : 0;
    det = cons >= 4;
    q.push_back(det);
  endtask
  // Compares each detect result against the oldest note.
  initial forever begin
    @(posedge sys_clk);
    #2;
    if (measDone === 1'b1) begin
      repeat (3) @(posedge sys_clk);
      #2 check("detect", q.pop_front(), detectOut);
    end
  end
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    paceIn = 1'b0;
    measDone = 1'b0;
    measExceeds = 1'b0;
    det = 1'b0;
    {cons, fails, samples_checked, expPulses, expFloats} = '0;
    rnd = 32'h0000003F;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    burst(0, 2000);
    burst(1, 2000);
    burst(1, 200);
    burst(1, 200);
    burst(1, 200);
    burst(1, 2000);
    burst(0, 2000);
    burst(1, 2000);
    burst(1, 200);
    fork
      begin
        repeat (50) @(posedge sys_clk);
        #1 clkEn = 1'b0;
        repeat (100) @(posedge sys_clk);
        #1 clkEn = 1'b1;
      end
    join_none
    burst(0, 300);
    paceIn = 1'b1;
    burst(1, 2000);
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      burst(rnd[0], 200);
    end
    paceIn = 1'b0;
    burst(0, 200);
    fork
      begin
        repeat (500) @(posedge sys_clk);
        #1 paceIn = 1'b1;
      end
    join_none
    burst(0, 502);
    repeat (3) @(posedge sys_clk);
    check("pulses", expPulses, pulses);
    check("floats", expFloats, swPulses);
    end_of_test;
  end
  initial begin
    #1000000;
    fails++;
    end_of_test;
  end
endmodule // testbench
`default_nettype wire

// ===== verif/touch_output_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "touch_output_health_pulse_defines.svh"
module touch_output_asserts (
  // Clock and reset.
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  // Watched outputs.
  input wire logic                     burstActive,
  input wire logic signed [`TRIM_W-1:0] oscTrim,
  input wire logic                     recalRequest,
  input wire logic                     detectOut,
  input wire logic                     detectOe
);
  logic [10:0] lowCnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Counts cycles of the float.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) lowCnt <= 11'h000;
    else lowCnt <= detectOe ? 11'h000 : lowCnt + 11'h001;
  end
  a_float_len: assert property ($rose(detectOe) |-> lowCnt == 11'h5DC)
    else $error("float length wrong");
  a_float_then_burst: assert property ($rose(detectOe) |-> burstActive)
    else $error("float not ended at burst start");
  a_burst_after_float: assert property ($rose(burstActive) |-> $rose(detectOe))
    else $error("burst without float");
  a_trim_idle: assert property (!burstActive [*3] |-> oscTrim == '0)
    else $error("trim outside burst");
  a_trim_bound: assert property (oscTrim <= 8'sh4B && oscTrim >= -8'sh4B)
    else $error("trim out of range");
  a_recal_clears: assert property (recalRequest |=> !detectOut [*8])
    else $error("output not low after recal");
  a_recal_was_on: assert property (recalRequest |-> detectOut)
    else $error("recal without detection");
  a_recal_pulse: assert property (recalRequest |=> !recalRequest)
    else $error("recal pulse too long");
  a_detect_quiet: assert property ($changed(detectOut) |-> !burstActive && detectOe)
    else $error("detect changed at wrong time");
  c_touch: cover property ($rose(detectOut));
  c_pulse: cover property ($fell(detectOe) && !detectOut);
  c_release: cover property ($fell(detectOut));
endmodule // touch_output_asserts
bind touch_output_health_pulse touch_output_asserts i_touch_output_asserts (
  .sys_clk, .rst_n, .burstActive, .oscTrim, .recalRequest, .detectOut, .detectOe);
`default_nettype wire
